/* File: tioc_consts.svh */
// Constants for the tracker output and indicator control block.
// Function
// - A clear-sequence-counter command sets the outgoing message sequence number to zero and is acknowledged.
// - A reboot command is acknowledged first and only then restarts the device.
// - A local-address query is answered with the current SIM IP address as a 32-bit value.
// - Pulling the panic input line to ground puts the device into emergency mode.
// - In emergency mode the device sends emergency reports carrying emergency type code 1.
// - Activating the immobilizer on output 1 while driving blocks progressively rather than at once.
// - During progressive blocking the active time grows by 90 ms in every 4 s period.
// - After 205032704 cycles (about 8.2 s at 25 MHz) of progressive blocking the immobilizer output stays active continuously.
// - A pulse output is active for the pulse-active time then inactive for the pulse-inactive time, both programmable.
// - Pulse timing is exact to the clock cycle and tests check exact cycle counts.
// - Output 1 goes high-impedance when active and output 2 is driven to ground when active.
// - The blue indicator blinks 1 normal, 2 server error, 3 packet-data error, 4 no network, 5 PIN locked, 6 no attach, 7 no SIM.
// - The red indicator blinks 1 normal, 2 no fix, 4 positioning chipset or antenna error.
// - An emergency acknowledgement in emergency state stops the emergency reports unless the panic line is still held low.
// - A pulse-type output, once commanded active, pulses and returns inactive by itself.
`ifndef TIOC_CONSTS_SVH
`define TIOC_CONSTS_SVH
`define TIOC_CLK_HZ 25000000
`define TIOC_CYC_PER_MS (`TIOC_CLK_HZ / 1000)
`define TIOC_RAMP_STEP_MS 90
`define TIOC_RAMP_PERIOD_MS 4000
`define TIOC_RAMP_TOTAL_MS 180000
`define TIOC_BLINK_ON_MS 200
`define TIOC_BLINK_OFF_MS 300
`define TIOC_BLINK_PAUSE_MS 2000
`define TIOC_EMG_TYPE 4'h1
`define TIOC_SEQ_RESET 16'h0000
`define TIOC_RESP_ACK 2'h1
`define TIOC_RESP_IP 2'h2
`endif

/* File: tioc_pkg.sv */
// Types shared by the tracker output and indicator control block.
package tioc_pkg;
	typedef enum logic [2:0] {TIOC_CMD_NONE, TIOC_CMD_CLEAR_SEQ, TIOC_CMD_REBOOT, TIOC_CMD_QUERY_IP,
		TIOC_CMD_EMG_ACK, TIOC_CMD_OUT_ON, TIOC_CMD_OUT_OFF} tioc_cmd_e;
	typedef enum logic [1:0] {TIOC_OUT_LEVEL, TIOC_OUT_IMMOB, TIOC_OUT_PULSE} tioc_omode_e;
	typedef struct packed {
		logic valid;
		tioc_cmd_e cmd;
		logic line;
	} tioc_cmd_s;
	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic [15:0] seq;
		logic [31:0] ip;
	} tioc_resp_s;
	typedef struct packed {
		logic [2:0] blue_code;
		logic [2:0] red_code;
	} tioc_status_s;
endpackage : tioc_pkg

/* File: tioc_blinker.sv */
// Blink-count indicator driver: shows a code as N blinks and a long pause.
`timescale 1ns/10ps
`include "tioc_consts.svh"
module tioc_blinker #(
	parameter int unsigned ON_CYC = `TIOC_BLINK_ON_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned OFF_CYC = `TIOC_BLINK_OFF_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned PAUSE_CYC = `TIOC_BLINK_PAUSE_MS * `TIOC_CYC_PER_MS
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [2:0] i_code,
	output logic o_led
);
	typedef struct packed {
		logic [26:0] tmr;
		logic [2:0] left;
		logic lit;
		logic pause;
		logic led;
	} tioc_blink_s;
	tioc_blink_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (s_q.tmr != 27'h0) begin
			s_d.tmr = s_q.tmr - 27'h1;
		end else if (s_q.pause || s_q.left == 3'h0) begin
			// Code is latched only at the start of a group so a change never cuts a group short.
			s_d.pause = 1'b0;
			s_d.left = i_code;
			s_d.lit = 1'b0;
			s_d.tmr = 27'h0;
			if (i_code != 3'h0) begin
				s_d.lit = 1'b1;
				s_d.tmr = 27'(ON_CYC - 1);
			end
		end else if (s_q.lit) begin
			s_d.lit = 1'b0;
			s_d.left = s_q.left - 3'h1;
			if (s_q.left == 3'h1) begin
				s_d.pause = 1'b1;
				s_d.tmr = 27'(PAUSE_CYC - 1);
			end else begin
				s_d.tmr = 27'(OFF_CYC - 1);
			end
		end else begin
			s_d.lit = 1'b1;
			s_d.tmr = 27'(ON_CYC - 1);
		end
		s_d.led = s_d.lit;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_led = s_q.led;
endmodule : tioc_blinker

/* File: tioc_top.sv */
// Output, panic input, command and indicator control for the tracker.
`timescale 1ns/10ps
`include "tioc_consts.svh"
module tioc_top #(
	parameter int unsigned RAMP_STEP_CYC = `TIOC_RAMP_STEP_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned RAMP_PERIOD_CYC = `TIOC_RAMP_PERIOD_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned RAMP_TOTAL_CYC = `TIOC_RAMP_TOTAL_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned BLINK_ON_CYC = `TIOC_BLINK_ON_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned BLINK_OFF_CYC = `TIOC_BLINK_OFF_MS * `TIOC_CYC_PER_MS,
	parameter int unsigned BLINK_PAUSE_CYC = `TIOC_BLINK_PAUSE_MS * `TIOC_CYC_PER_MS
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input tioc_pkg::tioc_cmd_s i_cmd,
	input wire logic [31:0] i_local_ip,
	input wire logic i_report_sent,
	input wire logic i_panic_input_line_n,
	input wire logic i_driving,
	input tioc_pkg::tioc_omode_e i_out1_mode,
	input tioc_pkg::tioc_omode_e i_out2_mode,
	input wire logic [31:0] i_pulse_on_cyc,
	input wire logic [31:0] i_pulse_off_cyc,
	input tioc_pkg::tioc_status_s i_status,
	output tioc_pkg::tioc_resp_s o_resp,
	output logic [15:0] o_seq,
	output logic o_emergency,
	output logic [3:0] o_emg_type,
	output logic o_reboot,
	output logic o_out1_oe,
	output logic o_out1_o,
	output logic o_out2_oe,
	output logic o_out2_o,
	output logic o_led_blue,
	output logic o_led_red
);
	import tioc_pkg::*;

	typedef struct packed {
		tioc_resp_s resp;
		logic [15:0] seq;
		logic emg;
		logic reboot_pend;
		logic reboot;
		logic [1:0] act;
		logic [1:0] phase_on;
		logic [63:0] ptmr;
		logic ramp;
		logic [31:0] rtmr;
		logic [31:0] ron;
		logic [31:0] rtotal;
	} tioc_state_s;
	tioc_state_s s_q, s_d;

	logic [1:0] drive;
	tioc_omode_e mode [2];
	assign mode[0] = i_out1_mode;
	assign mode[1] = i_out2_mode;

	always_comb begin
		s_d = s_q;
		s_d.resp.valid = 1'b0;
		s_d.reboot = 1'b0;
		// Reboot waits one cycle so the acknowledge is out before the restart strobe.
		if (s_q.reboot_pend) begin
			s_d.reboot = 1'b1;
			s_d.reboot_pend = 1'b0;
		end
		if (i_report_sent) begin
			s_d.seq = s_q.seq + 16'h1;
		end
		if (!i_panic_input_line_n) begin
			s_d.emg = 1'b1;
		end
		if (i_cmd.valid) begin
			s_d.resp.valid = 1'b1;
			s_d.resp.kind = `TIOC_RESP_ACK;
			s_d.resp.ip = 32'h0;
			case (i_cmd.cmd)
				TIOC_CMD_CLEAR_SEQ: begin
					s_d.seq = `TIOC_SEQ_RESET;
				end
				TIOC_CMD_REBOOT: begin
					s_d.reboot_pend = 1'b1;
				end
				TIOC_CMD_QUERY_IP: begin
					s_d.resp.kind = `TIOC_RESP_IP;
					s_d.resp.ip = i_local_ip;
				end
				TIOC_CMD_EMG_ACK: begin
					// A held panic line wins over the acknowledgement.
					if (i_panic_input_line_n) begin
						s_d.emg = 1'b0;
					end
				end
				TIOC_CMD_OUT_ON: begin
					s_d.act[i_cmd.line] = 1'b1;
					s_d.phase_on[i_cmd.line] = 1'b1;
					s_d.ptmr[i_cmd.line*32 +: 32] = i_pulse_on_cyc;
					if (i_cmd.line == 1'b0 && mode[0] == TIOC_OUT_IMMOB && i_driving) begin
						s_d.ramp = 1'b1;
						s_d.rtmr = 32'h0;
						s_d.ron = 32'(RAMP_STEP_CYC);
						s_d.rtotal = 32'h0;
					end
				end
				TIOC_CMD_OUT_OFF: begin
					s_d.act[i_cmd.line] = 1'b0;
					if (i_cmd.line == 1'b0) begin
						s_d.ramp = 1'b0;
					end
				end
				default: begin
					s_d.resp.valid = 1'b0;
				end
			endcase
		end
		s_d.resp.seq = s_d.seq;
		if (s_q.ramp) begin
			s_d.rtotal = s_q.rtotal + 32'h1;
			if (s_q.rtotal >= 32'(RAMP_TOTAL_CYC - 1)) begin
				s_d.ramp = 1'b0;
			end else if (s_q.rtmr >= 32'(RAMP_PERIOD_CYC - 1)) begin
				s_d.rtmr = 32'h0;
				s_d.ron = s_q.ron + 32'(RAMP_STEP_CYC);
			end else begin
				s_d.rtmr = s_q.rtmr + 32'h1;
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (s_q.act[i] && mode[i] == TIOC_OUT_PULSE && !(i_cmd.valid && i_cmd.line == 1'(i))) begin
				if (s_q.ptmr[i*32 +: 32] > 32'h1) begin
					s_d.ptmr[i*32 +: 32] = s_q.ptmr[i*32 +: 32] - 32'h1;
				end else if (s_q.phase_on[i]) begin
					s_d.phase_on[i] = 1'b0;
					s_d.ptmr[i*32 +: 32] = i_pulse_off_cyc;
				end else begin
					s_d.act[i] = 1'b0;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			drive[i] = s_q.act[i];
			if (mode[i] == TIOC_OUT_PULSE) begin
				drive[i] = s_q.act[i] && s_q.phase_on[i];
			end
		end
		if (s_q.ramp) begin
			drive[0] = s_q.rtmr < s_q.ron;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Output 1 releases the wire when active; output 2 pulls it low when active.
	assign o_out1_oe = !drive[0];
	assign o_out1_o = 1'b0;
	assign o_out2_oe = drive[1];
	assign o_out2_o = 1'b0;
	assign o_resp = s_q.resp;
	assign o_seq = s_q.seq;
	assign o_emergency = s_q.emg;
	assign o_emg_type = s_q.emg ? `TIOC_EMG_TYPE : 4'h0;
	assign o_reboot = s_q.reboot;

	tioc_blinker #(.ON_CYC(BLINK_ON_CYC), .OFF_CYC(BLINK_OFF_CYC), .PAUSE_CYC(BLINK_PAUSE_CYC)) u_blue (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_code(i_status.blue_code),
		.o_led(o_led_blue)
	);
	tioc_blinker #(.ON_CYC(BLINK_ON_CYC), .OFF_CYC(BLINK_OFF_CYC), .PAUSE_CYC(BLINK_PAUSE_CYC)) u_red (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_code(i_status.red_code),
		.o_led(o_led_red)
	);
endmodule : tioc_top

/* File: tioc_assertions.sv */
// Port checks for the tracker output and indicator control block.
`timescale 1ns/10ps
module tioc_assertions
	import tioc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input tioc_pkg::tioc_cmd_s i_cmd,
	input wire logic [31:0] i_local_ip,
	input wire logic i_report_sent,
	input wire logic i_panic_input_line_n,
	input tioc_pkg::tioc_omode_e i_out2_mode,
	input tioc_pkg::tioc_resp_s o_resp,
	input wire logic [15:0] o_seq,
	input wire logic o_emergency,
	input wire logic [3:0] o_emg_type,
	input wire logic o_reboot,
	input wire logic o_out1_o,
	input wire logic o_out2_oe,
	input wire logic o_out2_o
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	wire clr = i_cmd.valid && i_cmd.cmd == TIOC_CMD_CLEAR_SEQ;
	wire ack = i_cmd.valid && i_cmd.cmd == TIOC_CMD_EMG_ACK;
	a_clear_ack: assert property (clr |=> o_resp.valid && o_resp.kind == 2'h1 && o_seq == 16'h0000)
		else $error("clear not acked with zero sequence");
	a_reboot_order: assert property (i_cmd.valid && i_cmd.cmd == TIOC_CMD_REBOOT
		|=> o_resp.valid && !o_reboot ##1 o_reboot ##1 !o_reboot)
		else $error("reboot not after its ack");
	a_ip_reply: assert property (i_cmd.valid && i_cmd.cmd == TIOC_CMD_QUERY_IP
		|=> o_resp.valid && o_resp.kind == 2'h2 && o_resp.ip == $past(i_local_ip))
		else $error("address reply wrong");
	a_panic_emg: assert property (!i_panic_input_line_n |-> ##[1:2] o_emergency)
		else $error("panic gave no emergency");
	a_emg_type: assert property (o_emg_type == (o_emergency ? 4'h1 : 4'h0))
		else $error("emergency type wrong");
	a_ack_stops: assert property (ack && i_panic_input_line_n |-> ##[1:2] !o_emergency)
		else $error("ack did not end emergency");
	a_seq_step: assert property (i_report_sent && !clr |=> o_seq == $past(o_seq) + 16'h0001)
		else $error("sequence did not advance");
	a_pin_level: assert property (!o_out1_o && !(o_out2_oe && o_out2_o))
		else $error("output pin driven high");
	a_pulse_start: assert property (i_cmd.valid && i_cmd.cmd == TIOC_CMD_OUT_ON && i_cmd.line
		&& i_out2_mode == TIOC_OUT_PULSE |=> o_out2_oe)
		else $error("pulse did not start");
	c_reboot: cover property (o_reboot);
	c_emerg: cover property (o_emergency);
	c_pulse: cover property (o_out2_oe);
endmodule : tioc_assertions

/* File: tioc_wiring.sv */
// Vehicle wiring model that turns the output pins into active flags.
`timescale 1ns/10ps
module tioc_wiring (
	input wire logic i_out1_oe,
	input wire logic i_out1_o,
	input wire logic i_out2_oe,
	input wire logic i_out2_o,
	output logic o_act1,
	output logic o_act2
);
	// Both loads pull up, so a released line reads high, never the last value.
	assign o_act1 = i_out1_oe ? i_out1_o : 1'b1;
	assign o_act2 = !(i_out2_oe ? i_out2_o : 1'b1);
endmodule : tioc_wiring

/* File: testbench.sv */
// Self-checking bench for the tracker output and indicator control block.
`timescale 1ns/10ps
module testbench;
	import tioc_pkg::*;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	tioc_cmd_s i_cmd = '0;
	logic [31:0] ip = 32'hac101206;
	logic rs = 1'b0;
	logic pan_n = 1'b1;
	logic drv = 1'b1;
	logic [31:0] pon = 32'h5;
	logic [31:0] poff = 32'h3;
	tioc_omode_e m1 = TIOC_OUT_IMMOB;
	tioc_omode_e m2 = TIOC_OUT_PULSE;
	tioc_status_s st = '0;
	tioc_resp_s o_resp;
	logic [15:0] o_seq;
	logic emg, rbt, oe1, o1, oe2, o2, lb, lr, a1, a2;
	logic [3:0] ety;
	int mismatches = 0;
	int comparisons = 0;
	int k;
	wire [3:0] mon = {lr, lb, a2, a1};
	tioc_top #(.RAMP_STEP_CYC(9), .RAMP_PERIOD_CYC(40), .RAMP_TOTAL_CYC(200), .BLINK_ON_CYC(3),
		.BLINK_OFF_CYC(4), .BLINK_PAUSE_CYC(20)) tioc_top_i (.i_clock(i_clock), .i_rstn(i_rstn),
		.i_cmd(i_cmd), .i_local_ip(ip), .i_report_sent(rs), .i_panic_input_line_n(pan_n),
		.i_driving(drv), .i_out1_mode(m1), .i_out2_mode(m2), .i_pulse_on_cyc(pon),
		.i_pulse_off_cyc(poff), .i_status(st), .o_resp(o_resp), .o_seq(o_seq), .o_emergency(emg),
		.o_emg_type(ety), .o_reboot(rbt), .o_out1_oe(oe1), .o_out1_o(o1), .o_out2_oe(oe2),
		.o_out2_o(o2), .o_led_blue(lb), .o_led_red(lr));
	tioc_wiring tioc_wiring_i (.i_out1_oe(oe1), .i_out1_o(o1), .i_out2_oe(oe2), .i_out2_o(o2),
		.o_act1(a1), .o_act2(a2));
	initial begin
		forever #20 i_clock = ~i_clock;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input tioc_cmd_e c, input logic l);
		@(posedge i_clock);
		i_cmd <= '{1'b1, c, l};
		@(posedge i_clock);
		i_cmd <= '0;
		#1;
	endtask : send
	task automatic cnt(input int n, input int s, output int r);
		r = 0;
		// Sample first so the state launched by the command edge is counted too.
		repeat (n) begin
			r += mon[s];
			@(posedge i_clock);
			#1;
		end
	endtask : cnt
	task automatic t_seq;
		@(posedge i_clock);
		rs <= 1'b1;
		repeat (3) @(posedge i_clock);
		rs <= 1'b0;
		#1;
		chk(o_seq, 64'h3);
		@(posedge i_clock);
		i_cmd <= '{1'b1, TIOC_CMD_CLEAR_SEQ, 1'b0};
		rs <= 1'b1;
		@(posedge i_clock);
		i_cmd <= '0;
		rs <= 1'b0;
		#1;
		chk({o_resp.valid, o_resp.kind, o_seq}, {3'h5, 16'h0});
	endtask : t_seq
	task automatic t_cmds;
		send(TIOC_CMD_QUERY_IP, 1'b0);
		chk({o_resp.valid, o_resp.kind, o_resp.ip}, {3'h6, 32'hac101206});
		@(posedge i_clock);
		ip <= 32'hc0a80a01;
		send(TIOC_CMD_QUERY_IP, 1'b0);
		chk({o_resp.valid, o_resp.kind, o_resp.ip}, {3'h6, 32'hc0a80a01});
		send(TIOC_CMD_REBOOT, 1'b0);
		chk({o_resp.valid, o_resp.kind, rbt}, 64'ha);
		@(posedge i_clock);
		#1;
		chk(rbt, 64'h1);
	endtask : t_cmds
	task automatic t_panic;
		@(posedge i_clock);
		pan_n <= 1'b0;
		repeat (3) @(posedge i_clock);
		#1;
		chk({emg, ety}, 64'h11);
		send(TIOC_CMD_EMG_ACK, 1'b0);
		repeat (2) @(posedge i_clock);
		#1;
		chk(emg, 64'h1);
		pan_n <= 1'b1;
		send(TIOC_CMD_EMG_ACK, 1'b0);
		repeat (2) @(posedge i_clock);
		#1;
		chk({emg, ety}, 64'h0);
	endtask : t_panic
	task automatic t_outs;
		send(TIOC_CMD_OUT_ON, 1'b1);
		cnt(20, 1, k);
		chk(k, 64'd5);
		send(TIOC_CMD_OUT_ON, 1'b0);
		cnt(40, 0, k);
		chk(k, 64'd9);
		cnt(40, 0, k);
		chk(k, 64'd18);
		repeat (140) @(posedge i_clock);
		#1;
		cnt(20, 0, k);
		chk(k, 64'd20);
		send(TIOC_CMD_OUT_OFF, 1'b0);
		cnt(5, 0, k);
		chk(k, 64'd0);
		@(posedge i_clock);
		drv <= 1'b0;
		send(TIOC_CMD_OUT_ON, 1'b0);
		cnt(5, 0, k);
		chk(k, 64'd5);
		send(TIOC_CMD_OUT_OFF, 1'b0);
		@(posedge i_clock);
		pon <= 32'h2;
		poff <= 32'h2;
		send(TIOC_CMD_OUT_ON, 1'b1);
		cnt(10, 1, k);
		chk(k, 64'd2);
	endtask : t_outs
	task automatic t_leds;
		@(posedge i_clock);
		st <= '{3'h3, 3'h4};
		repeat (40) @(posedge i_clock);
		cnt(74, 2, k);
		chk(k, 64'd18);
		st <= '{3'h7, 3'h2};
		repeat (80) @(posedge i_clock);
		cnt(60, 3, k);
		chk(k, 64'd12);
	endtask : t_leds
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	initial begin
		repeat (6) @(posedge i_clock);
		i_rstn <= 1'b1;
		t_seq();
		t_cmds();
		t_panic();
		t_outs();
		t_leds();
		close_out();
	end
endmodule : testbench
bind tioc_top tioc_assertions tioc_assertions_i (.i_clock, .i_rstn, .i_cmd, .i_local_ip, .i_report_sent,
	.i_panic_input_line_n, .i_out2_mode, .o_resp, .o_seq, .o_emergency, .o_emg_type, .o_reboot,
	.o_out1_o, .o_out2_oe, .o_out2_o);
